//--- design/brx_map.svh
// Offsets, field positions and reset values of the bridge extension registers
`ifndef BRX_MAP_SVH
`define BRX_MAP_SVH
`define BRX_OFF_BASE_HI   8'h54
`define BRX_OFF_LIMIT_HI  8'h58
`define BRX_OFF_MASK_PORT 8'h64
`define BRX_RST_WORD      32'h0000_0000
`define BRX_RST_MASK      8'h00
`define BRX_RST_PIN       4'h0
`define BRX_MASK_RW       8'h7e
`define BRX_RETRY_EVENTS  8'h66
`define BRX_RETRY_LIMIT   25'h100_0000
`define BRX_CNT_STEP      25'h000_0001
`define BRX_F_CLR         8
`define BRX_F_SET         12
`define BRX_F_OEC         16
`define BRX_F_OES         20
`define BRX_F_IN          28
`define BRX_PIN_W         4
`define BRX_WORD_LSB      2
`endif

//--- design/brx_pkg.sv
// Types shared by the bridge extension register slice
package brx_pkg;
	typedef logic [31:0] brx_word_t;
	typedef logic [7:0]  brx_addr_t;
	typedef logic [3:0]  brx_be_t;
	typedef logic [3:0]  brx_pin_t;
	typedef logic [7:0]  brx_evt_t;
	typedef logic [24:0] brx_cnt_t;
	typedef logic [63:0] brx_addr64_t;
endpackage : brx_pkg

//--- design/brx_ext_cfg.sv
// Bridge extension config registers: upper window bits, error mask, aux pins
//
// Overview of operation
// - Read/write register holds upstream window base bits 63:32, reset zero.
// - Read/write register holds upstream window limit bits 63:32, reset zero.
// - With window enabled forward only inside base..limit; else outside downstream window.
// - Mask zero lets event raise system error if enable set; one suppresses.
// - Mask bit 1 gates the read-data-never-obtained retry exhaustion event.
// - Mask bit 2 gates posted write non-delivery after retry exhaustion.
// - Mask bit 3 gates target abort on posted write delivery.
// - Mask bit 4 gates master abort on posted write delivery.
// - Mask bit 5 gates delayed write non-delivery after retry exhaustion.
// - Mask bit 6 gates delayed read getting no data after retries.
// - Mask bits 0 and 7 and port bits 27:24 read zero.
// - Writing one to clear field drives matching pin low when bidirectional.
// - Writing one to set field drives matching pin high when bidirectional.
// - New pin levels appear the cycle after the config write.
// - Input-only pins are never driven, whatever set or clear writes.
// - Zeros written to set/clear fields do nothing; reads return last written.
// - Writing one to enable-clear field makes the pin input-only.
// - Writing one to enable-set field drives held data onto the pin.
// - Input field reports pin levels, updated the cycle after a change.
`timescale 1ns/1ps
`include "brx_map.svh"

module brx_ext_cfg #(
	parameter brx_pkg::brx_cnt_t RETRY_LIMIT = `BRX_RETRY_LIMIT
) (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               cfg_wr_en,
	input  wire logic               cfg_rd_en,
	input  wire brx_pkg::brx_addr_t cfg_addr,
	input  wire brx_pkg::brx_be_t   cfg_be,
	input  wire brx_pkg::brx_word_t cfg_wdata,
	output brx_pkg::brx_word_t      cfg_rdata,
	output logic                    cfg_rd_ack,
	input  wire logic               system_error_enable_bit,
	input  wire brx_pkg::brx_evt_t  evt_attempt_fail,
	input  wire brx_pkg::brx_evt_t  evt_txn_done,
	output logic                    primary_system_error_out_n,
	input  wire logic               up_req_valid,
	input  wire brx_pkg::brx_addr64_t up_req_addr,
	input  wire logic               up_win_en,
	input  wire brx_pkg::brx_word_t up_base_lo,
	input  wire brx_pkg::brx_word_t up_limit_lo,
	input  wire logic               up_in_down_win,
	output logic                    up_fwd,
	input  wire brx_pkg::brx_pin_t  gpio_in,
	output brx_pkg::brx_pin_t       gpio_out,
	output brx_pkg::brx_pin_t       gpio_oe
);
	import brx_pkg::*;

	localparam brx_evt_t MASK_RW  = `BRX_MASK_RW;
	localparam brx_evt_t RETRY_EV = `BRX_RETRY_EVENTS;

	// ==========================================================
	// Config decode
	brx_addr_t word_addr;
	logic      wr_base;
	logic      wr_limit;
	logic      wr_port;
	logic      rd_hit_port;

	assign word_addr   = {cfg_addr[7:`BRX_WORD_LSB], 2'b00};
	assign wr_base     = cfg_wr_en && (word_addr == `BRX_OFF_BASE_HI);
	assign wr_limit    = cfg_wr_en && (word_addr == `BRX_OFF_LIMIT_HI);
	assign wr_port     = cfg_wr_en && (word_addr == `BRX_OFF_MASK_PORT);
	assign rd_hit_port = word_addr == `BRX_OFF_MASK_PORT;

	function automatic brx_word_t be_merge(brx_word_t old_v, brx_word_t new_v, brx_be_t be);
		brx_word_t r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// ==========================================================
	// Register file
	brx_word_t base_hi;
	brx_word_t limit_hi;
	brx_evt_t  err_mask;
	brx_pin_t  f_clr;
	brx_pin_t  f_set;
	brx_pin_t  f_oec;
	brx_pin_t  f_oes;
	brx_pin_t  pin_in_q;
	brx_word_t next_base_hi;
	brx_word_t next_limit_hi;
	brx_evt_t  next_err_mask;
	brx_pin_t  next_f_clr;
	brx_pin_t  next_f_set;
	brx_pin_t  next_f_oec;
	brx_pin_t  next_f_oes;
	brx_pin_t  next_gpio_out;
	brx_pin_t  next_gpio_oe;
	brx_word_t next_rdata;
	brx_word_t port_word;
	brx_word_t port_wr;

	assign port_word = {pin_in_q, 4'h0, f_oes, f_oec, f_set, f_clr, err_mask & MASK_RW};
	assign port_wr   = be_merge(port_word, cfg_wdata, cfg_be);

	always_comb begin
		next_base_hi  = wr_base ? be_merge(base_hi, cfg_wdata, cfg_be) : base_hi;
		next_limit_hi = wr_limit ? be_merge(limit_hi, cfg_wdata, cfg_be) : limit_hi;
		next_err_mask = err_mask;
		next_f_clr    = f_clr;
		next_f_set    = f_set;
		next_f_oec    = f_oec;
		next_f_oes    = f_oes;
		next_gpio_out = gpio_out;
		next_gpio_oe  = gpio_oe;
		if (wr_port) begin
			next_err_mask = port_wr[7:0] & MASK_RW;
			// Fields keep the whole written value for readback, only ones act
			next_f_clr    = port_wr[`BRX_F_CLR +: `BRX_PIN_W];
			next_f_set    = port_wr[`BRX_F_SET +: `BRX_PIN_W];
			next_f_oec    = port_wr[`BRX_F_OEC +: `BRX_PIN_W];
			next_f_oes    = port_wr[`BRX_F_OES +: `BRX_PIN_W];
			// Set wins when a pin is both set and cleared in one write
			if (cfg_be[1]) begin
				next_gpio_out = (gpio_out & ~next_f_clr) | next_f_set;
			end
			if (cfg_be[2]) begin
				next_gpio_oe = (gpio_oe & ~next_f_oec) | next_f_oes;
			end
		end
		unique case (word_addr)
			`BRX_OFF_BASE_HI:   next_rdata = base_hi;
			`BRX_OFF_LIMIT_HI:  next_rdata = limit_hi;
			`BRX_OFF_MASK_PORT: next_rdata = port_word;
			default:            next_rdata = `BRX_RST_WORD;
		endcase
		if (!cfg_rd_en) begin
			next_rdata = `BRX_RST_WORD;
		end
	end

	// Pin outputs are flops, so levels land on the edge after the write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			base_hi    <= `BRX_RST_WORD;
			limit_hi   <= `BRX_RST_WORD;
			err_mask   <= `BRX_RST_MASK;
			f_clr      <= `BRX_RST_PIN;
			f_set      <= `BRX_RST_PIN;
			f_oec      <= `BRX_RST_PIN;
			f_oes      <= `BRX_RST_PIN;
			gpio_out   <= `BRX_RST_PIN;
			gpio_oe    <= `BRX_RST_PIN;
			pin_in_q   <= `BRX_RST_PIN;
			cfg_rdata  <= `BRX_RST_WORD;
			cfg_rd_ack <= 1'b0;
		end else begin
			base_hi    <= next_base_hi;
			limit_hi   <= next_limit_hi;
			err_mask   <= next_err_mask;
			f_clr      <= next_f_clr;
			f_set      <= next_f_set;
			f_oec      <= next_f_oec;
			f_oes      <= next_f_oes;
			gpio_out   <= next_gpio_out;
			gpio_oe    <= next_gpio_oe;
			pin_in_q   <= gpio_in;
			cfg_rdata  <= next_rdata;
			cfg_rd_ack <= cfg_rd_en;
		end
	end

	// ==========================================================
	// Upstream window decode
	brx_addr64_t win_base;
	brx_addr64_t win_limit;
	logic        next_up_fwd;

	assign win_base  = {base_hi, up_base_lo};
	assign win_limit = {limit_hi, up_limit_lo};

	always_comb begin
		if (!up_req_valid) begin
			next_up_fwd = 1'b0;
		end else if (up_win_en) begin
			next_up_fwd = (up_req_addr >= win_base) && (up_req_addr <= win_limit);
		end else begin
			next_up_fwd = !up_in_down_win;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			up_fwd <= 1'b0;
		end else begin
			up_fwd <= next_up_fwd;
		end
	end

	// ==========================================================
	// Error events and system error output
	brx_evt_t hit;
	logic     next_serr_n;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_evt
			if (RETRY_EV[gi]) begin : g_retry
				brx_cnt_t cnt;
				brx_cnt_t next_cnt;
				logic     at_lim;
				assign at_lim = cnt == brx_cnt_t'(RETRY_LIMIT - `BRX_CNT_STEP);
				// A finished transaction restarts the count for the next one
				always_comb begin
					next_cnt = cnt;
					if (evt_txn_done[gi]) begin
						next_cnt = '0;
					end else if (evt_attempt_fail[gi]) begin
						next_cnt = at_lim ? '0 : cnt + `BRX_CNT_STEP;
					end
				end
				always_ff @(posedge clk_sys) begin
					if (rst) begin
						cnt <= '0;
					end else begin
						cnt <= next_cnt;
					end
				end
				assign hit[gi] = evt_attempt_fail[gi] && !evt_txn_done[gi] && at_lim;
				property p_retry_lim;
					@(posedge clk_sys) disable iff (rst)
					hit[gi] |=> (cnt == '0);
				endproperty
				a_retry_lim: assert property (p_retry_lim)
					else $error("retry count did not restart after the limit");
			end else if (MASK_RW[gi]) begin : g_direct
				assign hit[gi] = evt_attempt_fail[gi];
			end else begin : g_none
				assign hit[gi] = 1'b0;
			end
		end
	endgenerate

	// Mask bits: 1, 2, 5, 6 retry kinds; 3 target abort; 4 master abort
	always_comb begin
		next_serr_n = !(system_error_enable_bit && |(hit & ~err_mask & MASK_RW));
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			primary_system_error_out_n <= 1'b1;
		end else begin
			primary_system_error_out_n <= next_serr_n;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_base_wr;
		wr_base && (cfg_be == 4'hf) |=> base_hi == $past(cfg_wdata);
	endproperty
	a_base_wr: assert property (p_base_wr)
		else $error("base high word not stored");
	property p_limit_rd;
		cfg_rd_en && (word_addr == `BRX_OFF_LIMIT_HI)
			|=> cfg_rd_ack && (cfg_rdata == $past(limit_hi));
	endproperty
	a_limit_rd: assert property (p_limit_rd)
		else $error("limit high word read mismatch");
	property p_win_off;
		up_req_valid && !up_win_en |=> up_fwd == !$past(up_in_down_win);
	endproperty
	a_win_off: assert property (p_win_off)
		else $error("upstream decode wrong with window disabled");
	property primary_system_error_pin_tabort;
		evt_attempt_fail[3] && !err_mask[3] && system_error_enable_bit |=> !primary_system_error_out_n;
	endproperty
	a_serr_tabort: assert property (primary_system_error_pin_tabort)
		else $error("unmasked target abort did not raise system error");
	property primary_system_error_pin_off;
		!system_error_enable_bit |=> primary_system_error_out_n;
	endproperty
	a_serr_off: assert property (primary_system_error_pin_off)
		else $error("system error raised while disabled");
	property p_rsvd;
		cfg_rd_en && rd_hit_port |=> !cfg_rdata[0] && !cfg_rdata[7] && (cfg_rdata[27:24] == 4'h0);
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bits read nonzero");

	property p_pin_set;
		wr_port && cfg_be[1] |=> gpio_out == (($past(gpio_out) & ~$past(cfg_wdata[11:8]))
			| $past(cfg_wdata[15:12]));
	endproperty
	a_pin_set: assert property (p_pin_set)
		else $error("pin data not updated the cycle after write");
	property p_oe_clr;
		wr_port && cfg_be[2] |=> gpio_oe == (($past(gpio_oe) & ~$past(cfg_wdata[19:16]))
			| $past(cfg_wdata[23:20]));
	endproperty
	a_oe_clr: assert property (p_oe_clr)
		else $error("pin enable not updated the cycle after write");

	property p_in_rd;
		cfg_rd_en && rd_hit_port |=> cfg_rdata[31:28] == $past(gpio_in, 2);
	endproperty
	a_in_rd: assert property (p_in_rd)
		else $error("input field does not track pins");

	property p_rst_pins;
		$fell(rst) |-> (gpio_oe == 4'h0) && (gpio_out == 4'h0);
	endproperty
	a_rst_pins: assert property (@(posedge clk_sys) p_rst_pins)
		else $error("pins not idle after reset");

	property p_cov_drive;
		wr_port && cfg_be[2] && (cfg_wdata[23:20] != 4'h0) ##1 (gpio_oe != 4'h0);
	endproperty
	c_drive: cover property (p_cov_drive);

	property p_cov_serr;
		!primary_system_error_out_n;
	endproperty
	c_serr: cover property (p_cov_serr);

	property p_cov_win;
		up_req_valid && up_win_en ##1 up_fwd;
	endproperty
	c_win: cover property (p_cov_win);

endmodule : brx_ext_cfg

//--- tb/brx_host.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
module brx_host (
	input  wire logic               clk_sys,
	output logic                    cfg_wr_en,
	output logic                    cfg_rd_en,
	output brx_pkg::brx_addr_t      cfg_addr,
	output brx_pkg::brx_be_t        cfg_be,
	output brx_pkg::brx_word_t      cfg_wdata,
	input  wire brx_pkg::brx_word_t cfg_rdata,
	input  wire logic               cfg_rd_ack
);
	import brx_pkg::*;
	initial begin
		cfg_wr_en = 1'b0;
		cfg_rd_en = 1'b0;
		cfg_addr  = 8'h00;
		cfg_be    = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end
	// Released lines flip so stale values never pass for live ones
	task automatic idle();
		cfg_addr  = ~cfg_addr;
		cfg_be    = ~cfg_be;
		cfg_wdata = ~cfg_wdata;
	endtask : idle
	task automatic wr(input brx_addr_t a, input brx_be_t b, input brx_word_t d);
		@(negedge clk_sys);
		cfg_addr  = a;
		cfg_be    = b;
		cfg_wdata = d;
		cfg_wr_en = 1'b1;
		@(negedge clk_sys);
		cfg_wr_en = 1'b0;
		idle();
	endtask : wr
	task automatic rd(input brx_addr_t a, output brx_word_t d, output logic ok);
		@(negedge clk_sys);
		cfg_addr  = a;
		cfg_be    = 4'hf;
		cfg_rd_en = 1'b1;
		@(negedge clk_sys);
		// Answer stands one cycle only, so take it before the next edge
		d         = cfg_rdata;
		ok        = cfg_rd_ack;
		cfg_rd_en = 1'b0;
		idle();
	endtask : rd
endmodule : brx_host

//--- tb/tb_brx_ext_cfg.sv
// Self-checking bench for the bridge extension register slice
`timescale 1ns/1ps
`include "brx_map.svh"
module tb_brx_ext_cfg;
	import brx_pkg::*;
	localparam brx_addr_t mp = `BRX_OFF_MASK_PORT;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        cfg_wr_en, cfg_rd_en, cfg_rd_ack, primary_system_error_out_n, up_fwd;
	brx_addr_t   cfg_addr;
	brx_be_t     cfg_be;
	brx_word_t   cfg_wdata, cfg_rdata;
	logic        system_error_enable_bit = 1'b1;
	brx_evt_t    evt_attempt_fail = 8'h00;
	brx_evt_t    evt_txn_done = 8'h00;
	logic        up_req_valid = 1'b0;
	brx_addr64_t up_req_addr = 64'h0000_0000_0000_0000;
	logic        up_win_en = 1'b0;
	brx_word_t   up_base_lo = 32'h0000_1000;
	brx_word_t   up_limit_lo = 32'h0000_1fff;
	logic        up_in_down_win = 1'b0;
	brx_pin_t    gpio_in = 4'ha;
	brx_pin_t    gpio_out, gpio_oe;
	int          fails = 0;
	int          compares = 0;
	int          lows = 0;
	int          n;
	always #4 clk_sys = ~clk_sys;
	brx_ext_cfg #(.RETRY_LIMIT(25'h000_0003)) u_brx_ext_cfg (.clk_sys, .rst, .cfg_wr_en,
		.cfg_rd_en, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_ack,
		.system_error_enable_bit, .evt_attempt_fail, .evt_txn_done, .primary_system_error_out_n,
		.up_req_valid, .up_req_addr, .up_win_en, .up_base_lo, .up_limit_lo, .up_in_down_win,
		.up_fwd, .gpio_in, .gpio_out, .gpio_oe);
	brx_host u_brx_host (.clk_sys, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_be, .cfg_wdata,
		.cfg_rdata, .cfg_rd_ack);
	always @(negedge clk_sys) if (primary_system_error_out_n === 1'b0) lows++;
	// ==========================================
	// Check helpers
	task automatic chk(input string nm, input brx_word_t got, input brx_word_t exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rchk(input brx_addr_t a, input brx_word_t exp);
		brx_word_t d;
		logic      ok;
		u_brx_host.rd(a, d, ok);
		chk("read ack", brx_word_t'(ok), 32'h0000_0001);
		chk($sformatf("reg %h", a), d, exp);
	endtask : rchk
	task automatic pins(input brx_pin_t oe, input brx_pin_t out);
		chk("pin enable", brx_word_t'(gpio_oe), brx_word_t'(oe));
		chk("pin data", brx_word_t'(gpio_out), brx_word_t'(out));
	endtask : pins
	// Pulses n failures of one kind, then closes the transaction
	task automatic ev(input int k, input int cnt, input int exp);
		lows = 0;
		repeat (cnt) begin
			@(negedge clk_sys);
			evt_attempt_fail = brx_evt_t'(8'h01 << k);
		end
		@(negedge clk_sys);
		evt_attempt_fail = 8'h00;
		evt_txn_done     = brx_evt_t'(8'h01 << k);
		@(negedge clk_sys);
		evt_txn_done = 8'h00;
		repeat (3) @(negedge clk_sys);
		chk($sformatf("error pulses kind %0d", k), brx_word_t'(lows), brx_word_t'(exp));
	endtask : ev
	task automatic win(input brx_addr64_t a, input logic en, input logic dn, input logic exp);
		@(negedge clk_sys);
		up_req_valid   = 1'b1;
		up_req_addr    = a;
		up_win_en      = en;
		up_in_down_win = dn;
		@(negedge clk_sys);
		chk("forward", brx_word_t'(up_fwd), brx_word_t'(exp));
	endtask : win
	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	// ==========================================
	// Tests
	initial begin
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		pins(4'h0, 4'h0);
		rchk(`BRX_OFF_BASE_HI, 32'h0000_0000);
		rchk(`BRX_OFF_LIMIT_HI, 32'h0000_0000);
		rchk(mp, 32'ha000_0000);
		u_brx_host.wr(`BRX_OFF_BASE_HI, 4'hf, 32'h1234_5678);
		u_brx_host.wr(`BRX_OFF_LIMIT_HI, 4'h5, 32'hffff_ffff);
		u_brx_host.wr(8'h60, 4'hf, 32'hffff_ffff);
		rchk(`BRX_OFF_BASE_HI, 32'h1234_5678);
		rchk(`BRX_OFF_LIMIT_HI, 32'h00ff_00ff);
		rchk(8'h60, 32'h0000_0000);
		u_brx_host.wr(mp, 4'h9, 32'hffff_ffff);
		rchk(mp, 32'ha000_007e);
		u_brx_host.wr(mp, 4'h1, 32'h0000_0000);
		$display("test registers ended");
		u_brx_host.wr(mp, 4'h2, 32'h0000_f000);
		pins(4'h0, 4'hf);
		u_brx_host.wr(mp, 4'h4, 32'h0050_0000);
		pins(4'h5, 4'hf);
		u_brx_host.wr(mp, 4'h2, 32'h0000_0300);
		pins(4'h5, 4'hc);
		rchk(mp, 32'ha050_0300);
		u_brx_host.wr(mp, 4'h2, 32'h0000_0000);
		pins(4'h5, 4'hc);
		u_brx_host.wr(mp, 4'h4, 32'h0001_0000);
		pins(4'h4, 4'hc);
		gpio_in = 4'h5;
		repeat (2) @(negedge clk_sys);
		rchk(mp, 32'h5001_0000);
		$display("test pins ended");
		for (int k = 1; k < 7; k++) begin
			n = (k == 3 || k == 4) ? 1 : 3;
			ev(k, n - 1, 0);
			ev(k, n, 1);
			u_brx_host.wr(mp, 4'h1, brx_word_t'(8'h01 << k));
			ev(k, n, 0);
			u_brx_host.wr(mp, 4'h1, 32'h0000_0000);
		end
		system_error_enable_bit = 1'b0;
		ev(2, 3, 0);
		system_error_enable_bit = 1'b1;
		$display("test errors ended");
		u_brx_host.wr(`BRX_OFF_BASE_HI, 4'hf, 32'h0000_0001);
		u_brx_host.wr(`BRX_OFF_LIMIT_HI, 4'hf, 32'h0000_0001);
		win(64'h0000_0001_0000_1000, 1'b1, 1'b0, 1'b1);
		win(64'h0000_0001_0000_1fff, 1'b1, 1'b1, 1'b1);
		win(64'h0000_0001_0000_2000, 1'b1, 1'b0, 1'b0);
		win(64'h0000_0000_0000_1000, 1'b1, 1'b0, 1'b0);
		win(64'h0000_0002_0000_1000, 1'b1, 1'b0, 1'b0);
		win(64'h0000_0002_0000_1000, 1'b0, 1'b0, 1'b1);
		win(64'h0000_0001_0000_1000, 1'b0, 1'b1, 1'b0);
		$display("test window ended");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		stop_test();
	end
endmodule : tb_brx_ext_cfg
